// file: dv/frame_trig_model.sv
`timescale 1ns/1ps
`default_nettype none
module frame_trig_model (
  input  wire logic sys_clk,     // System clock
  input  wire logic arst_n,      // Async reset, active low
  input  wire logic wait_trig,   // Device waiting for trigger
  input  wire logic fire,        // Request one trigger
  input  wire logic fire_bad,    // Fire at once, ignoring status
  output logic      frame_trig   // Trigger pin, idle low
);
  logic       pend;
  logic [2:0] hold;

  // Pulse the pin high for four cycles, while the device waits, or at once on fire_bad
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend       <= 1'b0;
      hold       <= 3'h0;
      frame_trig <= 1'b0;
    end else begin
      if (fire) begin
        pend <= 1'b1;
      end
      if (hold != 3'h0) begin
        hold <= hold - 3'h1;
        if (hold == 3'h1) begin
          frame_trig <= 1'b0;
        end
      end else if ((pend && wait_trig) || fire_bad) begin
        frame_trig <= 1'b1;
        hold       <= 3'h4;
        pend       <= 1'b0;
      end
    end
  end
endmodule : frame_trig_model
`default_nettype wire

// file: dv/tb_parameter_set_sequencer_soft_advance.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
`define WAITFOR(c) while (!(c)) @(posedge sys_clk);
module tb_parameter_set_sequencer_soft_advance;
  import seq_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} row_t;
  logic               sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, frame_trig;
  logic               wait_trig, load_busy, frame_active, fire, fire_bad;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [PARAM_W-1:0] active_param;
  logic [IDX_W-1:0]   active_index;
  logic               err;
  int                 fails, tests_run, cyc, i;
  row_t               rows [14];

  seq_soft_advance dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_trig(frame_trig), .wait_trig(wait_trig), .load_busy(load_busy),
    .frame_active(frame_active), .active_param(active_param), .active_index(active_index));
  frame_trig_model src_u (.sys_clk(sys_clk), .arst_n(arst_n), .wait_trig(wait_trig), .fire(fire),
    .fire_bad(fire_bad), .frame_trig(frame_trig));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle, trigger request and closing report
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task frame_on();
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    `WAITFOR(frame_active === 1'b1)
  endtask : frame_on
  // Soft commands only: latency is unknown, so checks wait on status
  task cmd(input logic [31:0] c);
    apb(1'b1, OFF_CMD, c);
    `WAITFOR(load_busy === 1'b1)
    `WAITFOR(wait_trig === 1'b1)
  endtask : cmd
  task test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; fire = 1'b0; fire_bad = 1'b0;
    rows = '{'{1, OFF_SEL, 32'h0, 32'h0, 0}, '{1, OFF_SET_DATA, 32'h0a00, 32'h0, 0},
             '{1, OFF_SEL, 32'h1, 32'h0, 0}, '{1, OFF_SET_DATA, 32'h0b11, 32'h0, 0},
             '{1, OFF_SEL, 32'h2, 32'h0, 0}, '{1, OFF_SET_DATA, 32'h0c22, 32'h0, 0},
             '{0, OFF_SET_DATA, 32'h0, 32'h0c22, 0}, '{1, OFF_COUNT, 32'h3, 32'h0, 0},
             '{0, OFF_COUNT, 32'h0, 32'h3, 0}, '{1, OFF_BASE, 32'h1234, 32'h0, 0},
             '{0, OFF_BASE, 32'h0, 32'h1234, 0}, '{0, 8'h24, 32'h0, 32'h0, 1},
             '{1, 8'h06, 32'h5, 32'h0, 1}, '{0, OFF_STATUS, 32'h0, 32'h0, 0}};
    repeat (5) @(posedge sys_clk);
    `CHK("wait in reset", 1'b0, wait_trig)
    `CHK("param in reset", 16'h0, active_param)
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Register table rows
    for (i = 0; i < 14; i++) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      `CHK("slverr", rows[i].err, err)
      if (!rows[i].wr) `CHK("rdata", rows[i].e, rd)
    end
    $display("test registers done");
    // Enable loads set 0
    apb(1'b1, OFF_CTRL, 32'h1);
    `WAITFOR(load_busy === 1'b1)
    `WAITFOR(wait_trig === 1'b1)
    `CHK("enable param", 16'h0a00, active_param)
    `CHK("enable index", 6'h0, active_index)
    // Advance written mid-frame waits for the frame
    frame_on();
    `CHK("rising edge used", 1'b1, frame_trig)
    apb(1'b1, OFF_CMD, 32'h1);
    `CHK("pending param", 16'h0a00, active_param)
    `CHK("frame kept", 1'b1, frame_active)
    `WAITFOR(frame_active === 1'b0)
    `WAITFOR(load_busy === 1'b1)
    `CHK("wait drops", 1'b0, wait_trig)
    `WAITFOR(wait_trig === 1'b1)
    `CHK("advance param", 16'h0b11, active_param)
    `CHK("advance index", 6'h1, active_index)
    $display("test advance done");
    // Trigger landing inside a set copy
    apb(1'b1, OFF_CMD, 32'h1);
    fire_bad <= 1'b1;
    @(posedge sys_clk);
    fire_bad <= 1'b0;
    `WAITFOR(load_busy === 1'b1)
    `WAITFOR(wait_trig === 1'b1)
    repeat (6) @(posedge sys_clk);
    `CHK("no frame", 1'b0, frame_active)
    apb(1'b0, OFF_IGNORED, 32'h0);
    `CHK("ignored count", 32'h1, rd)
    frame_on();
    `CHK("frame param", 16'h0c22, active_param)
    `CHK("frame index", 6'h2, active_index)
    `WAITFOR(frame_active === 1'b0)
    $display("test ignored trigger done");
    // Wrap after the last set, then restart
    cmd(32'h1);
    `CHK("wrap index", 6'h0, active_index)
    `CHK("wrap param", 16'h0a00, active_param)
    cmd(32'h1);
    cmd(32'h2);
    `CHK("restart index", 6'h0, active_index)
    `CHK("restart param", 16'h0a00, active_param)
    $display("test wrap and restart done");
    // Hardware advance source: soft commands are ignored
    apb(1'b1, OFF_CTRL, 32'h3);
    apb(1'b1, OFF_CMD, 32'h1);
    repeat (3) @(posedge sys_clk);
    `CHK("hw src no load", 1'b0, load_busy)
    `CHK("hw src index", 6'h0, active_index)
    // Falling trigger edge, then disable during that frame
    apb(1'b1, OFF_CTRL, 32'h5);
    frame_on();
    `CHK("falling edge used", 1'b0, frame_trig)
    `CHK("falling frame index", 6'h0, active_index)
    apb(1'b1, OFF_CTRL, 32'h0);
    `CHK("frame finishes", 1'b1, frame_active)
    `WAITFOR(frame_active === 1'b0)
    repeat (3) @(posedge sys_clk);
    `CHK("base restored", 16'h1234, active_param)
    `CHK("cycling stopped", 1'b0, wait_trig)
    $display("test disable done");
    test_done();
  end
endmodule : tb_parameter_set_sequencer_soft_advance
`default_nettype wire

// file: src/param_store.sv
`timescale 1ns/1ps
`default_nettype none
module param_store
  import seq_pkg::*;
(
  input  wire logic                         sys_clk,  // System clock
  input  wire logic                         arst_n,   // Async reset, active low
  input  wire logic                         wr_en,    // Write strobe
  input  wire logic [seq_pkg::IDX_W-1:0]    wr_idx,   // Write index
  input  wire logic [seq_pkg::PARAM_W-1:0]  wr_data,  // Write data
  input  wire logic [seq_pkg::IDX_W-1:0]    a_idx,    // Load read index
  output logic      [seq_pkg::PARAM_W-1:0]  a_data,   // Load read data
  input  wire logic [seq_pkg::IDX_W-1:0]    b_idx,    // Bus read index
  output logic      [seq_pkg::PARAM_W-1:0]  b_data    // Bus read data
);
  logic [PARAM_W-1:0] sets [SET_MAX];

  // One flip-flop row per stored set
  for (genvar i = 0; i < SET_MAX; i++) begin : g_row
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        sets[i] <= SET_RST;
      end else if (wr_en && wr_idx == IDX_W'(i)) begin
        sets[i] <= wr_data;
      end
    end
  end

  assign a_data = sets[a_idx];
  assign b_data = sets[b_idx];
endmodule : param_store
`default_nettype wire

// file: src/seq_pkg.sv
// Notes on behaviour
// R1: With no hardware advance source, move to the next set only on soft advance.
// R2: With no hardware advance source, restart the cycle only on soft restart.
// R3: On enable, copy stored set 0 into the active set.
// R4: Each accepted frame trigger uses the active set, selection unchanged.
// R5: A soft advance taking effect copies the next stored set into the active set.
// R6: A soft restart taking effect copies stored set 0 into the active set.
// R7: Until a pending command takes effect, frames keep using the old active set.
// R8: While a set is copied, the waiting-for-trigger status drops.
// R9: Frame triggers arriving during a set copy are ignored.
// R10: Trigger source sends triggers only while waiting status shows, never during a copy; the model's fire_bad input fires regardless of status.
// R11: After the last set of a cycle, the next advance wraps to set 0.
// R12: Valid set indices run from 0 to stored_set_count minus one.
// R13: Disable during a frame lets that frame finish, then cycling stops.
// R14: On disable, the active set returns to its pre-enable values.
// R15: Software-only advance suits testing, not real time; command latency is unpredictable.
// R16: Pending commands are applied only between frames, while waiting for a trigger.
package seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned SET_MAX = 64;
  localparam int unsigned IDX_W   = 6;
  localparam int unsigned CNT_W   = 7;
  localparam int unsigned PARAM_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned LOAD_TIME_NS  = 400;
  localparam int unsigned FRAME_TIME_NS = 3000;
  localparam int unsigned LOAD_CYCLES   = (LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FRAME_CYCLES  = (FRAME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_CMD      = 8'h04;
  localparam logic [7:0] OFF_COUNT    = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0c;
  localparam logic [7:0] OFF_SEL      = 8'h10;
  localparam logic [7:0] OFF_SET_DATA = 8'h14;
  localparam logic [7:0] OFF_BASE     = 8'h18;
  localparam logic [7:0] OFF_ACTIVE   = 8'h1c;
  localparam logic [7:0] OFF_IGNORED  = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_SRC_BIT  = 1;
  localparam int unsigned CTRL_EDGE_BIT = 2;
  localparam int unsigned CMD_ADV_BIT   = 0;
  localparam int unsigned CMD_RST_BIT   = 1;
  localparam int unsigned ST_IDX_LSB    = 0;
  localparam int unsigned ST_WAIT_BIT   = 8;
  localparam int unsigned ST_LOAD_BIT   = 9;
  localparam int unsigned ST_FRAME_BIT  = 10;
  localparam int unsigned ST_ADVP_BIT   = 11;
  localparam int unsigned ST_RSTP_BIT   = 12;
  localparam int unsigned ST_EN_BIT     = 13;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0]         CTRL_RST  = 3'h0;
  localparam logic [CNT_W-1:0]   COUNT_RST = 7'h01;
  localparam logic [PARAM_W-1:0] BASE_RST  = 16'h0000;
  localparam logic [PARAM_W-1:0] SET_RST   = 16'h0000;

  typedef enum logic [1:0] {
    S_OFF,
    S_LOAD,
    S_WAIT,
    S_FRAME
  } seq_state_t;

endpackage : seq_pkg

// file: src/seq_soft_advance.sv
`timescale 1ns/1ps
`default_nettype none
module seq_soft_advance
  import seq_pkg::*;
(
  input  wire logic                         sys_clk,       // System clock, 10 MHz
  input  wire logic                         arst_n,        // Async reset, active low
  input  wire logic                         psel,          // APB select
  input  wire logic                         penable,       // APB enable
  input  wire logic                         pwrite,        // APB direction
  input  wire logic [7:0]                   paddr,         // APB byte address
  input  wire logic [31:0]                  pwdata,        // APB write data
  output logic      [31:0]                  prdata,        // APB read data
  output logic                              pready,        // APB ready
  output logic                              pslverr,       // APB error
  input  wire logic                         frame_trig,    // Frame start trigger pin
  output logic                              wait_trig,     // Waiting for frame trigger
  output logic                              load_busy,     // Set copy in progress
  output logic                              frame_active,  // Exposure and readout
  output logic      [seq_pkg::PARAM_W-1:0]  active_param,  // Active set parameters
  output logic      [seq_pkg::IDX_W-1:0]    active_index   // Index of active set
);
  import seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  seq_state_t         state;
  seq_state_t         next_state;
  logic               enable;
  logic               advance_source_select;
  logic               trigger_edge_select;
  logic [CNT_W-1:0]   stored_set_count;
  logic [IDX_W-1:0]   sel_idx;
  logic [PARAM_W-1:0] base_param;
  logic [15:0]        ignored_cnt;
  logic               adv_pend;
  logic               rst_pend;
  logic [IDX_W-1:0]   load_idx;
  logic [IDX_W-1:0]   next_idx;
  logic [2:0]         load_cnt;
  logic [4:0]         frame_cnt;
  logic [PARAM_W-1:0] store_rd;
  logic [PARAM_W-1:0] store_bus;
  logic               trig_edge;
  logic               wr_acc;
  logic               setup;
  logic               soft_next_set_command;
  logic               soft_cycle_restart_command;
  logic               cmd_ok;
  logic [31:0]        rd_mux;

  // Mapped offsets of the register file
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a <= OFF_IGNORED) && (a[1:0] == 2'b00);
  endfunction : reg_hit

  // Usable set count, clamped to 1..SET_MAX
  function automatic logic [CNT_W-1:0] eff_count(input logic [CNT_W-1:0] c);
    if (c == '0) eff_count = CNT_W'(1);
    else if (c > CNT_W'(SET_MAX)) eff_count = CNT_W'(SET_MAX);
    else eff_count = c;
  endfunction : eff_count

  ////////////////////////////////////////////////////////////////////////////
  // Submodules
  trig_sync u_trig (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .trig_pin    (frame_trig),
    .falling_sel (trigger_edge_select),
    .trig_edge   (trig_edge)
  );

  param_store u_store (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .wr_en   (wr_acc && paddr == OFF_SET_DATA),
    .wr_idx  (sel_idx),
    .wr_data (pwdata[PARAM_W-1:0]),
    .a_idx   (load_idx),
    .a_data  (store_rd),
    .b_idx   (sel_idx),
    .b_data  (store_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite && reg_hit(paddr);

  // Zero-wait answer, error on unmapped address
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !reg_hit(paddr);
      if (setup && !pwrite) prdata <= rd_mux;
    end
  end

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_CTRL: begin
        rd_mux[CTRL_EN_BIT]   = enable;
        rd_mux[CTRL_SRC_BIT]  = advance_source_select;
        rd_mux[CTRL_EDGE_BIT] = trigger_edge_select;
      end
      OFF_COUNT:    rd_mux[CNT_W-1:0] = stored_set_count;
      OFF_STATUS: begin
        rd_mux[ST_IDX_LSB +: IDX_W] = active_index;
        rd_mux[ST_WAIT_BIT]  = wait_trig;
        rd_mux[ST_LOAD_BIT]  = load_busy;
        rd_mux[ST_FRAME_BIT] = frame_active;
        rd_mux[ST_ADVP_BIT]  = adv_pend;
        rd_mux[ST_RSTP_BIT]  = rst_pend;
        rd_mux[ST_EN_BIT]    = (state != S_OFF);
      end
      OFF_SEL:      rd_mux[IDX_W-1:0] = sel_idx;
      OFF_SET_DATA: rd_mux[PARAM_W-1:0] = store_bus;
      OFF_BASE:     rd_mux[PARAM_W-1:0] = base_param;
      OFF_ACTIVE:   rd_mux[PARAM_W-1:0] = active_param;
      OFF_IGNORED:  rd_mux[15:0] = ignored_cnt;
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Configuration registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {trigger_edge_select, advance_source_select, enable} <= CTRL_RST;
      stored_set_count <= COUNT_RST;
      sel_idx          <= '0;
      base_param       <= BASE_RST;
    end else if (wr_acc) begin
      unique case (paddr)
        OFF_CTRL: begin
          enable                <= pwdata[CTRL_EN_BIT];
          advance_source_select <= pwdata[CTRL_SRC_BIT];
          trigger_edge_select   <= pwdata[CTRL_EDGE_BIT];
        end
        OFF_COUNT: stored_set_count <= pwdata[CNT_W-1:0];
        OFF_SEL:   sel_idx <= pwdata[IDX_W-1:0];
        OFF_BASE:  base_param <= pwdata[PARAM_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft commands, honoured only with no hardware advance source
  assign cmd_ok = wr_acc && paddr == OFF_CMD && !advance_source_select && enable; // [R1] [R2]
  assign soft_next_set_command      = cmd_ok && pwdata[CMD_ADV_BIT];
  assign soft_cycle_restart_command = cmd_ok && pwdata[CMD_RST_BIT];

  // Pending flags; a new command wins over the clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      adv_pend <= 1'b0;
      rst_pend <= 1'b0;
    end else begin
      if (soft_next_set_command) adv_pend <= 1'b1;
      else if (state == S_OFF || (state == S_WAIT && next_state == S_LOAD)) adv_pend <= 1'b0;
      if (soft_cycle_restart_command) rst_pend <= 1'b1;
      else if (state == S_OFF || (state == S_WAIT && next_state == S_LOAD)) rst_pend <= 1'b0;
    end
  end

  // Next index wraps at the end of the cycle
  always_comb begin
    if (7'(active_index) + 7'd1 >= eff_count(stored_set_count)) next_idx = '0; // [R11] [R12]
    else next_idx = active_index + 6'd1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state machine
  always_comb begin
    next_state = state;
    unique case (state)
      S_OFF:   if (enable) next_state = S_LOAD; // [R3]
      S_LOAD:  if (load_cnt == '0) next_state = S_WAIT;
      S_WAIT: begin
        if (!enable) next_state = S_OFF;
        else if (adv_pend || rst_pend) next_state = S_LOAD; // [R16] [R7]
        else if (trig_edge) next_state = S_FRAME; // [R4]
      end
      S_FRAME: if (frame_cnt == '0) next_state = enable ? S_WAIT : S_OFF; // [R13]
    endcase
  end

  // State, counters and load target
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= S_OFF;
      load_cnt  <= '0;
      frame_cnt <= '0;
      load_idx  <= '0;
    end else begin
      state <= next_state;
      if (state != S_LOAD && next_state == S_LOAD) begin
        load_cnt <= 3'(LOAD_CYCLES - 1);
        if (state == S_OFF || rst_pend) load_idx <= '0; // [R3] [R6] [R2]
        else load_idx <= next_idx; // [R1] [R5]
      end else if (load_cnt != '0) begin
        load_cnt <= load_cnt - 3'd1;
      end
      if (next_state == S_FRAME && state == S_WAIT) frame_cnt <= 5'(FRAME_CYCLES - 1);
      else if (frame_cnt != '0) frame_cnt <= frame_cnt - 5'd1;
    end
  end

  // Active set: copy at end of load, restore on disable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_param <= BASE_RST;
      active_index <= '0;
    end else if (state == S_LOAD && load_cnt == '0) begin
      active_param <= store_rd; // [R5] [R6]
      active_index <= load_idx;
    end else if (next_state == S_OFF) begin
      active_param <= base_param; // [R14]
      active_index <= '0;
    end
  end

  // Status outputs and ignored-trigger count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_trig    <= 1'b0;
      load_busy    <= 1'b0;
      frame_active <= 1'b0;
      ignored_cnt  <= 16'h0000;
    end else begin
      wait_trig    <= (next_state == S_WAIT); // [R8]
      load_busy    <= (next_state == S_LOAD);
      frame_active <= (next_state == S_FRAME);
      if (state == S_LOAD && trig_edge && ignored_cnt != 16'hffff) ignored_cnt <= ignored_cnt + 16'h0001; // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_load_start;
    state == S_WAIT && enable && (adv_pend || rst_pend);
  endsequence

  sequence s_load_end;
    state == S_LOAD && load_cnt == '0;
  endsequence

  sequence s_frame_start;
    state == S_WAIT && enable && !adv_pend && !rst_pend && trig_edge;
  endsequence

  // Set copy
  a_load_no_wait: assert property (state == S_LOAD |-> !wait_trig) // [R8]
    else $error("waiting status shown during set copy");
  a_trig_ignored: assert property (state == S_LOAD && trig_edge |=> state != S_FRAME) // [R9]
    else $error("trigger accepted during set copy");
  a_enable_zero: assert property (state == S_OFF && enable |=> state == S_LOAD && load_idx == '0) // [R3]
    else $error("enable did not load set 0");
  a_restart_zero: assert property (s_load_start and rst_pend |=> load_idx == '0) // [R6]
    else $error("restart did not target set 0");
  a_advance_next: assert property (s_load_start and !rst_pend |=> load_idx == $past(next_idx)) // [R1]
    else $error("advance did not target next set");
  a_load_copies: assert property (s_load_end |=> active_param == $past(store_rd) // [R5]
    && active_index == $past(load_idx))
    else $error("active set not copied from store");
  a_load_length: assert property (s_load_start |=> (state == S_LOAD) [*4] ##1 state == S_WAIT) // [R16]
    else $error("set copy length wrong");

  // Frame behaviour
  a_frame_start: assert property (s_frame_start |=> state == S_FRAME && frame_active) // [R4]
    else $error("accepted trigger did not start a frame");
  a_frame_stable: assert property (state == S_FRAME |-> $stable(active_param) && $stable(active_index)) // [R7]
    else $error("active set changed during frame");
  a_frame_finishes: assert property (state == S_FRAME && frame_cnt != '0 |=> state == S_FRAME) // [R13]
    else $error("frame cut short");
  a_frame_stop: assert property (state == S_FRAME && frame_cnt == '0 && !enable |=> state == S_OFF) // [R13]
    else $error("cycling went on after disable");
  a_disable_restore: assert property ($rose(state == S_OFF) |-> active_param == $past(base_param)) // [R14]
    else $error("active set not restored on disable");

  // Cycle wrap
  a_wrap_zero: assert property (s_load_start and !rst_pend // [R11]
    and active_index == IDX_W'(eff_count(stored_set_count) - CNT_W'(1)) |=> load_idx == '0)
    else $error("cycle did not wrap to set 0");

  // Bus answer and command gating
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not a single cycle");
  a_hw_src_blocks: assert property (advance_source_select && !adv_pend && !rst_pend // [R1] [R2]
    |=> !adv_pend && !rst_pend)
    else $error("soft command taken with hardware source");
endmodule : seq_soft_advance
`default_nettype wire

// file: src/trig_sync.sv
`timescale 1ns/1ps
`default_nettype none
module trig_sync (
  input  wire logic sys_clk,      // System clock
  input  wire logic arst_n,       // Async reset, active low
  input  wire logic trig_pin,     // Raw trigger pin
  input  wire logic falling_sel,  // 0 upward_transition, 1 falling
  output logic      trig_edge     // One-cycle selected edge
);
  logic meta;
  logic sync;
  logic prev;

  // Two-stage synchroniser, then edge history
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= trig_pin;
      sync <= meta;
      prev <= sync;
    end
  end

  // Edge of the chosen polarity
  assign trig_edge = falling_sel ? (prev & ~sync) : (sync & ~prev);
endmodule : trig_sync
`default_nettype wire
